// *** src/conv_pkg.sv ***
package conv_pkg;
  localparam int SAMPLE_W   = 8;
  localparam int COEF_W     = 8;
  localparam int TAPS       = 7;
  localparam int FILTERS    = 3;
  localparam int NCOEF      = 21;
  localparam int ACC_W      = 24;
  localparam int XBUS_W     = 22;
  localparam int THR_W      = 24;
  localparam int CNT_W      = 22;
  localparam int ADDR_W     = 9;
  localparam int HDATA_W    = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int SHIFT_MAX  = 8;

  // Host locations
  localparam logic [8:0] COEF_BANK1_OFF = 9'h100;
  localparam logic [7:0] COEF_LIMIT     = 8'h54;
  localparam logic [8:0] ACR_OFF        = 9'h0c0;
  localparam logic [8:0] SCR_OFF        = 9'h0c4;
  localparam logic [8:0] BACKEND_CFG_ZERO_OFF       = 9'h0c8;
  localparam logic [8:0] BACKEND_CFG_ONE_OFF       = 9'h0cc;
  localparam logic [8:0] THR_BUF_OFF    = 9'h0b0;
  localparam logic [8:0] THR_COPY_OFF   = 9'h0b4;
  localparam logic [8:0] CNT_BUF_OFF    = 9'h0b8;
  localparam logic [8:0] CNT_COPY_OFF   = 9'h0bc;

  // Field positions
  localparam int ACR_BANK    = 0;
  localparam int ACR_RUN     = 1;
  localparam int SCR_SWAP    = 0;
  localparam int SCR_DSIGNED = 1;
  localparam int SCR_CSIGNED = 2;
  localparam int SCR_WINDOW  = 3;
  localparam int BACKEND_CFG_ZERO_CZERO  = 0;
  localparam int BACKEND_CFG_ZERO_SH_LO  = 1;
  localparam int BACKEND_CFG_ZERO_RC_LO  = 6;
  localparam int BACKEND_CFG_ONE_MAXMIN = 0;
  localparam int BACKEND_CFG_ONE_STATIC = 1;
  localparam int THR_OVP     = 22;
  localparam int THR_OVN     = 23;

  // Reset values
  localparam logic [7:0] ACR_RST  = 8'h00;
  localparam logic [7:0] SCR_RST  = 8'h00;
  localparam logic [7:0] BACKEND_CFG_ZERO_RST = 8'h00;
  localparam logic [7:0] BACKEND_CFG_ONE_RST = 8'h00;

  localparam logic signed [23:0] XPOS_MAX = 24'sh1fffff;
  localparam logic signed [23:0] XNEG_MIN = -24'sh200000;
  localparam logic [21:0]        CNT_MAX  = 22'h3fffff;

  typedef struct packed {
    logic [7:0] s2;
    logic [7:0] s1;
    logic [7:0] s0;
  } sample_t;

  typedef struct packed {
    logic        ovn;
    logic        ovp;
    logic [21:0] data;
  } xbus_t;

  typedef enum logic [1:0] {
    RECT_NONE = 2'b00,
    RECT_FULL = 2'b01,
    RECT_HALF = 2'b10
  } rect_t;

  typedef enum logic [3:0] {
    MODE_MIN   = 4'b0001,
    MODE_MAX   = 4'b0010,
    MODE_UNDER = 4'b0100,
    MODE_OVER  = 4'b1000
  } stat_mode_t;
endpackage

// *** src/conv_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != DEPTH[PW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= push ? wp_q + 1'b1 : wp_q;
      rp_q  <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  fifo_bound_a: assert property (@(posedge clock) disable iff (!nrst)
    cnt_q <= DEPTH[PW:0]) else $error("fifo count beyond depth");
endmodule

// Notes on behaviour
// - Three 7-stage filters, chained as 21 stages or fed as a 3x7 window
// - Each filter broadcasts its sample to all stages; stage adds previous registered sum
// - Each filter output passes one register before the next filter's first stage
// - Samples and coefficients are eight bits wide
// - Two coefficient banks; bank bit picks active one; switch never stalls samples
// - Continuous swap exchanges banks after every sample; bank bit picks first
// - Sample and coefficient signedness chosen separately
// - Products and sums kept at full precision
// - Shifter: right up to 8 with rounding, left up to 8, five-bit field
// - Cascade adder adds shifter output and rounding to cascade input or zero
// - 22-bit sum flags positive and negative overflow at the signed limits
// - Two bits pick none, full or half rectification onto the transform bus
// - Monitor only observes; threshold, buffers, counter and signed comparator
// - Max/min bit and static bit choose among four monitor modes
// - Overshoot counts samples above threshold, saturating; overflow handling fixed
// - Undershoot counts samples below threshold and negative overflows
// - Max mode loads larger sample as threshold and counts
// - Min mode loads smaller sample as threshold and counts
// - Overflowed samples never replace the threshold
// - Threshold bits 22 and 23 are sticky overflow flags cleared by copy write
// - Copy locations move buffer to register on write, register to buffer on read
// - Copies accepted at any time while data flows
// - After reset the monitor is a min register
module conv_core
  import conv_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire sample_t       sample_in,
  input  wire logic          sample_valid,
  output logic               sample_ready,
  input  wire logic [21:0]   cascade_in,
  input  wire logic [8:0]    host_addr,
  input  wire logic [23:0]   host_wdata,
  input  wire logic          host_wr,
  input  wire logic          host_rd,
  output logic [23:0]        host_rdata,
  output xbus_t              xbus_out,
  output logic               xbus_valid
);
  function automatic logic signed [8:0] ext8(input logic [7:0] v, input logic sgn);
    return {sgn & v[7], v};
  endfunction

  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    return a == off;
  endfunction

  logic [7:0]  acr_q, scr_q, backend_cfg_zero_q, backend_cfg_one_q;
  logic [7:0]  coef_q [2][NCOEF];
  logic        bank_q;
  logic [23:0] thr_q, thr_buf_q;
  logic [21:0] cnt_q, cnt_buf_q;
  logic        mv_q, xv_q;
  xbus_t       x_q;

  // Sample path through the FIFO; host stalls it by clearing the run bit
  sample_t f_data;
  logic    f_valid;
  wire     step = f_valid & acr_q[ACR_RUN];

  sample_fifo #(.WIDTH($bits(sample_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .nrst      (nrst),
    .in_data   (sample_in),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (acr_q[ACR_RUN])
  );

  // Host decode
  wire       wr_acr   = host_wr & hit(host_addr, ACR_OFF);
  wire       wr_scr   = host_wr & hit(host_addr, SCR_OFF);
  wire       wr_backend_cfg_zero  = host_wr & hit(host_addr, BACKEND_CFG_ZERO_OFF);
  wire       wr_backend_cfg_one  = host_wr & hit(host_addr, BACKEND_CFG_ONE_OFF);
  wire       wr_tbuf  = host_wr & hit(host_addr, THR_BUF_OFF);
  wire       wr_cbuf  = host_wr & hit(host_addr, CNT_BUF_OFF);
  wire       wr_tcopy = host_wr & hit(host_addr, THR_COPY_OFF);
  wire       wr_ccopy = host_wr & hit(host_addr, CNT_COPY_OFF);
  wire       rd_tcopy = host_rd & hit(host_addr, THR_COPY_OFF);
  wire       rd_ccopy = host_rd & hit(host_addr, CNT_COPY_OFF);
  wire       coef_hit = (host_addr[7:0] < COEF_LIMIT) && (host_addr[1:0] == 2'b00)
                        && ((host_addr & ~COEF_BANK1_OFF) == {1'b0, host_addr[7:0]});
  wire [4:0] coef_idx = host_addr[6:2];
  wire       coef_bnk = host_addr[8];

  always_ff @(posedge clock) begin
    if (!nrst) begin
      acr_q  <= ACR_RST;
      scr_q  <= SCR_RST;
      backend_cfg_zero_q <= BACKEND_CFG_ZERO_RST;
      backend_cfg_one_q <= BACKEND_CFG_ONE_RST;
    end else begin
      acr_q  <= wr_acr ? host_wdata[7:0] : acr_q;
      scr_q  <= wr_scr ? host_wdata[7:0] : scr_q;
      backend_cfg_zero_q <= wr_backend_cfg_zero ? host_wdata[7:0] : backend_cfg_zero_q;
      backend_cfg_one_q <= wr_backend_cfg_one ? host_wdata[7:0] : backend_cfg_one_q;
    end
  end

  // Host may load either bank; the idle one is safe to rewrite mid-stream
  always_ff @(posedge clock) begin
    if (host_wr && coef_hit) begin
      coef_q[coef_bnk][coef_idx] <= host_wdata[7:0];
    end
  end

  // Active bank: follows the bank bit, or toggles per sample in swap mode
  wire bank_d = scr_q[SCR_SWAP] ? (step ? ~bank_q : bank_q) : acr_q[ACR_BANK];
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bank_q <= 1'b0;
    end else begin
      bank_q <= bank_d;
    end
  end

  swap_step_a: assert property (@(posedge clock) disable iff (!nrst)
    (scr_q[SCR_SWAP] && $past(scr_q[SCR_SWAP]) && step) |=> bank_q != $past(bank_q))
    else $error("bank not exchanged after sample");

  // MAC array: linear mode broadcasts tap 0 to every filter
  wire [7:0] tap [FILTERS];
  assign tap[0] = f_data.s0;
  assign tap[1] = scr_q[SCR_WINDOW] ? f_data.s1 : f_data.s0;
  assign tap[2] = scr_q[SCR_WINDOW] ? f_data.s2 : f_data.s0;

  logic signed [ACC_W-1:0] acc_q   [FILTERS][TAPS];
  logic signed [ACC_W-1:0] chain_q [FILTERS];

  for (genvar k = 0; k < FILTERS; k++) begin : g_filt
    wire signed [8:0] xs = ext8(tap[k], scr_q[SCR_DSIGNED]);
    for (genvar j = 0; j < TAPS; j++) begin : g_stage
      wire signed [8:0]       cs   = ext8(coef_q[bank_q][k*TAPS+j], scr_q[SCR_CSIGNED]);
      wire signed [17:0]      prod = xs * cs;
      wire signed [ACC_W-1:0] prev;
      if (j == 0 && k == 0) begin : g_first
        assign prev = '0;
      end else if (j == 0) begin : g_link
        assign prev = chain_q[k-1];
      end else begin : g_inner
        assign prev = acc_q[k][j-1];
      end
      wire signed [ACC_W-1:0] sum  = prev + ACC_W'(prod);
      wire signed [ACC_W-1:0] nxt  = step ? sum : acc_q[k][j];
      always_ff @(posedge clock) begin
        if (!nrst) begin
          acc_q[k][j] <= '0;
        end else begin
          acc_q[k][j] <= nxt;
        end
      end
    end
    always_ff @(posedge clock) begin
      if (!nrst) begin
        chain_q[k] <= '0;
      end else begin
        chain_q[k] <= step ? acc_q[k][TAPS-1] : chain_q[k];
      end
    end
  end

  chain_delay_a: assert property (@(posedge clock) disable iff (!nrst)
    step |=> chain_q[0] == $past(acc_q[0][TAPS-1]))
    else $error("chain register did not take filter output");

  // Backend shifter: signed five-bit amount, positive shifts right
  wire signed [4:0]  sh_amt = backend_cfg_zero_q[BACKEND_CFG_ZERO_SH_LO +: 5];
  wire               sh_rt  = ~sh_amt[4];
  wire signed [5:0]  sh_neg = -{sh_amt[4], sh_amt};
  wire [3:0]         rn     = (sh_rt && sh_amt > 5'sd8) ? 4'd8 : sh_amt[3:0];
  wire [3:0]         ln     = (sh_neg > 6'sd8) ? 4'd8 : sh_neg[3:0];
  wire signed [31:0] mac32  = 32'(acc_q[FILTERS-1][TAPS-1]);
  wire signed [31:0] shd    = sh_rt ? (mac32 >>> rn) : (mac32 <<< ln);
  wire               rnd    = sh_rt && (rn != 4'd0) && mac32[rn - 4'd1];
  wire signed [21:0] sh22   = shd[21:0];

  // Cascade adder; wide sum exposes the true value for overflow tests
  wire signed [21:0] cas    = backend_cfg_zero_q[BACKEND_CFG_ZERO_CZERO] ? 22'sd0 : cascade_in;
  wire signed [23:0] tsum   = 24'(sh22) + 24'(cas) + {23'd0, rnd};
  wire               ovp    = tsum > XPOS_MAX;
  wire               ovn    = tsum < XNEG_MIN;
  wire signed [21:0] asum   = tsum[21:0];

  // Rectifier; the most negative value has no positive twin and saturates
  wire signed [21:0] mag    = (asum == 22'sh200000) ? 22'sh1fffff : -asum;
  wire [21:0]        rect   = (rect_t'(backend_cfg_zero_q[BACKEND_CFG_ZERO_RC_LO +: 2]) == RECT_FULL && asum[21]) ? mag
                            : (rect_t'(backend_cfg_zero_q[BACKEND_CFG_ZERO_RC_LO +: 2]) == RECT_HALF && asum[21]) ? '0
                            : asum;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mv_q <= 1'b0;
      xv_q <= 1'b0;
      x_q  <= '0;
    end else begin
      mv_q <= step;
      xv_q <= mv_q;
      x_q  <= '{ovn: ovn, ovp: ovp, data: rect};
    end
  end

  assign xbus_out   = x_q;
  assign xbus_valid = xv_q;

  half_rect_a: assert property (@(posedge clock) disable iff (!nrst)
    (mv_q && backend_cfg_zero_q[BACKEND_CFG_ZERO_RC_LO +: 2] == 2'b10) |=> !x_q.data[21])
    else $error("half-wave result negative");

  ovf_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    ##1 (x_q.ovp == $past(tsum > 24'sd2097151)) && (x_q.ovn == $past(tsum < -24'sd2097152)))
    else $error("overflow flags wrong");

  // Statistics monitor
  stat_mode_t mode;
  assign mode = backend_cfg_one_q[BACKEND_CFG_ONE_STATIC] ? (backend_cfg_one_q[BACKEND_CFG_ONE_MAXMIN] ? MODE_OVER : MODE_UNDER)
                                    : (backend_cfg_one_q[BACKEND_CFG_ONE_MAXMIN] ? MODE_MAX : MODE_MIN);

  wire signed [21:0] thr = thr_q[21:0];
  wire signed [21:0] xd  = x_q.data;
  wire               gt  = x_q.ovp || (!x_q.ovn && xd > thr);
  wire               lt  = x_q.ovn || (!x_q.ovp && xd < thr);
  logic              cnt_ev;
  logic              thr_ld;
  always_comb begin
    cnt_ev = 1'b0;
    thr_ld = 1'b0;
    case (mode)
      MODE_OVER:  cnt_ev = gt;
      MODE_UNDER: cnt_ev = lt;
      MODE_MAX: begin
        cnt_ev = gt && !x_q.ovp;
        thr_ld = gt && !x_q.ovp;
      end
      MODE_MIN: begin
        cnt_ev = lt && !x_q.ovn;
        thr_ld = lt && !x_q.ovn;
      end
      default: begin
        cnt_ev = 1'b0;
        thr_ld = 1'b0;
      end
    endcase
  end

  // Host copy wins over a concurrent sample update; sticky sets beat the clear
  wire [21:0] cnt_inc = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 22'd1;
  wire [21:0] cnt_d   = wr_ccopy ? cnt_buf_q : ((xv_q && cnt_ev) ? cnt_inc : cnt_q);
  wire [21:0] thr_v   = wr_tcopy ? thr_buf_q[21:0] : ((xv_q && thr_ld) ? x_q.data : thr_q[21:0]);
  wire        sp_d    = (wr_tcopy ? 1'b0 : thr_q[THR_OVP]) | (xv_q & x_q.ovp);
  wire        sn_d    = (wr_tcopy ? 1'b0 : thr_q[THR_OVN]) | (xv_q & x_q.ovn);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      thr_q     <= '0;
      cnt_q     <= '0;
      thr_buf_q <= '0;
      cnt_buf_q <= '0;
    end else begin
      thr_q     <= {sn_d, sp_d, thr_v};
      cnt_q     <= cnt_d;
      thr_buf_q <= rd_tcopy ? thr_q : (wr_tbuf ? host_wdata : thr_buf_q);
      cnt_buf_q <= rd_ccopy ? cnt_q : (wr_cbuf ? host_wdata[21:0] : cnt_buf_q);
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  logic [23:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (coef_hit) begin
      rd_mux = {16'h0000, coef_q[coef_bnk][coef_idx]};
    end else begin
      case (host_addr)
        ACR_OFF:      rd_mux = {16'h0000, acr_q};
        SCR_OFF:      rd_mux = {16'h0000, scr_q};
        BACKEND_CFG_ZERO_OFF:     rd_mux = {16'h0000, backend_cfg_zero_q};
        BACKEND_CFG_ONE_OFF:     rd_mux = {16'h0000, backend_cfg_one_q};
        THR_BUF_OFF:  rd_mux = thr_buf_q;
        CNT_BUF_OFF:  rd_mux = {2'b00, cnt_buf_q};
        THR_COPY_OFF: rd_mux = thr_q;
        CNT_COPY_OFF: rd_mux = {2'b00, cnt_q};
        default:      rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      host_rdata <= '0;
    end else begin
      host_rdata <= host_rd ? rd_mux : host_rdata;
    end
  end

  cnt_sat_a: assert property (@(posedge clock) disable iff (!nrst)
    (cnt_q == 22'h3fffff && !wr_ccopy) |=> cnt_q == 22'h3fffff)
    else $error("counter wrapped");

  sticky_ovf_a: assert property (@(posedge clock) disable iff (!nrst)
    (xv_q && x_q.ovp) |=> thr_q[22])
    else $error("positive overflow flag lost");

  copy_read_a: assert property (@(posedge clock) disable iff (!nrst)
    rd_tcopy |=> thr_buf_q == $past(thr_q))
    else $error("threshold snapshot wrong");

  thr_guard_a: assert property (@(posedge clock) disable iff (!nrst)
    (xv_q && (x_q.ovp || x_q.ovn) && !wr_tcopy) |=> thr_q[21:0] == $past(thr_q[21:0]))
    else $error("overflow sample loaded threshold");

  reset_mode_a: assert property (@(posedge clock)
    !nrst |=> mode == MODE_MIN)
    else $error("monitor not min register after reset");

  over_cnt_a: assert property (@(posedge clock) disable iff (!nrst)
    (xv_q && mode == MODE_OVER && x_q.ovn && !wr_ccopy) |=> cnt_q == $past(cnt_q))
    else $error("negative overflow counted as overshoot");
endmodule

`default_nettype wire

// *** bench/conv_source.sv ***
`timescale 1ns/1ps
`default_nettype none

module conv_source
  import conv_pkg::*;
(
  input  wire logic clock,
  input  wire logic sample_ready,
  output var sample_t sample_in,
  output var logic    sample_valid
);
  logic [23:0] q[$];
  logic        took;

  initial begin
    sample_in    = '0;
    sample_valid = 1'b0;
    took         = 1'b0;
  end

  always @(posedge clock) begin
    took <= sample_valid && sample_ready;
  end

  // An offer holds until taken; idle lanes toggle so stale data never looks valid
  always @(negedge clock) begin
    if (took)
      void'(q.pop_front());
    if (q.size() > 0) begin
      sample_valid <= 1'b1;
      sample_in    <= q[0];
    end else begin
      sample_valid <= 1'b0;
      sample_in    <= ~sample_in;
    end
  end
endmodule

`default_nettype wire

// *** bench/mac_array_backend_stats_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module mac_array_backend_stats_tb;
  import conv_pkg::*;
  logic        clock, nrst, sample_valid, sample_ready;
  logic        host_wr, host_rd, xbus_valid;
  sample_t     sample_in;
  xbus_t       xbus_out;
  logic [21:0] cascade_in;
  logic [8:0]  host_addr;
  logic [23:0] host_wdata, host_rdata, rd;
  logic [23:0] last = '0;
  logic [23:0] prev = '0;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n_out = 0;

  conv_core dut (.clock(clock), .nrst(nrst), .sample_in(sample_in),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .cascade_in(cascade_in),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .xbus_out(xbus_out), .xbus_valid(xbus_valid));

  conv_source src (.clock(clock), .sample_ready(sample_ready), .sample_in(sample_in),
    .sample_valid(sample_valid));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (xbus_valid === 1'b1) begin
      prev  <= last;
      last  <= xbus_out;
      n_out <= n_out + 1;
    end
  end

  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [23:0] d);
    @(negedge clock);
    host_addr  = a;
    host_wdata = d;
    host_wr    = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
  endtask

  task automatic rdr(input logic [8:0] a);
    @(negedge clock);
    host_addr = a;
    host_rd   = 1'b1;
    @(negedge clock);
    host_rd = 1'b0;
    rd      = host_rdata;
  endtask

  task automatic cfg(input logic [7:0] access_control_reg, input logic [7:0] setup_control_reg, input logic [7:0] b0);
    wr(ACR_OFF, {16'h0000, access_control_reg});
    wr(SCR_OFF, {16'h0000, setup_control_reg});
    wr(BACKEND_CFG_ZERO_OFF, {16'h0000, b0});
  endtask

  // Bounded wait so a stalled pipeline ends as a mismatch, not a hang
  task automatic wait_out(input int base, input int n);
    for (int i = 0; i < 400 && n_out < base + n; i++)
      @(negedge clock);
    chk("outputs", 24'(n_out - base), 24'(n));
  endtask

  task automatic burst(input logic [23:0] s, input int n);
    int base;
    base = n_out;
    repeat (n) src.q.push_back(s);
    wait_out(base, n);
  endtask

  // Thirty samples settle the 21-stage pipeline whatever tap holds the coefficient
  task automatic drow(input int idx, input logic [7:0] c0, input logic [7:0] c1,
                      input logic [7:0] access_control_reg, input logic [7:0] setup_control_reg, input logic [7:0] b0,
                      input logic [21:0] casc, input logic [23:0] smp, input logic [23:0] exp);
    wr(9'(4 * idx), {16'h0000, c0});
    wr(COEF_BANK1_OFF + 9'(4 * idx), {16'h0000, c1});
    cfg(access_control_reg, setup_control_reg, b0);
    cascade_in = casc;
    burst(smp, 30);
    chk("xbus", last, exp);
    wr(9'(4 * idx), 24'h000000);
    wr(COEF_BANK1_OFF + 9'(4 * idx), 24'h000000);
  endtask

  task automatic ld(input logic [23:0] thr, input logic [23:0] cnt);
    wr(THR_BUF_OFF, thr);
    wr(THR_COPY_OFF, 24'h000000);
    wr(CNT_BUF_OFF, cnt);
    wr(CNT_COPY_OFF, 24'h000000);
  endtask

  task automatic rd_stats(input logic [23:0] ethr, input logic [23:0] ecnt);
    rdr(THR_COPY_OFF);
    rdr(THR_BUF_OFF);
    chk("threshold", rd, ethr);
    rdr(CNT_COPY_OFF);
    rdr(CNT_BUF_OFF);
    chk("counter", rd, ecnt);
  endtask

  task automatic srow(input logic [7:0] b1, input logic [23:0] thr, input logic [23:0] cnt,
                      input logic [21:0] casc, input logic [23:0] ethr, input logic [23:0] ecnt);
    wr(BACKEND_CFG_ONE_OFF, {16'h0000, b1});
    ld(thr, cnt);
    cascade_in = casc;
    burst(24'h000000, 3);
    rd_stats(ethr, ecnt);
  endtask

  task automatic t_regs;
    rdr(ACR_OFF);
    chk("acr", rd, {16'h0000, ACR_RST});
    rdr(SCR_OFF);
    chk("scr", rd, {16'h0000, SCR_RST});
    rdr(BACKEND_CFG_ZERO_OFF);
    chk("backend_cfg_zero", rd, {16'h0000, BACKEND_CFG_ZERO_RST});
    rdr(BACKEND_CFG_ONE_OFF);
    chk("backend_cfg_one", rd, {16'h0000, BACKEND_CFG_ONE_RST});
    wr(BACKEND_CFG_ONE_OFF, 24'h000003);
    rdr(BACKEND_CFG_ONE_OFF);
    chk("backend_cfg_one rw", rd, 24'h000003);
    wr(9'h1fc, 24'h00005a);
    rdr(9'h1fc);
    chk("unmapped", rd, 24'h000000);
    wr(BACKEND_CFG_ONE_OFF, 24'h000000);
  endtask

  task automatic t_path;
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 22'h0, 24'h05, 24'h000005);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h3d, 22'h0, 24'h05, 24'h000014);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h31, 22'h0, 24'h05, 24'h000500);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 22'h0, 24'h05, 24'h000003);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h11, 22'h0, 24'hff, 24'h000001);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h13, 22'h0, 24'hff, 24'h000001);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h02, 8'h41, 22'h0, 24'hfb, 24'h000005);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h02, 8'h81, 22'h0, 24'hfb, 24'h000000);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h02, 8'h01, 22'h0, 24'hfb, 24'h3ffffb);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h02, 8'hc1, 22'h0, 24'hfb, 24'h3ffffb);
    drow(0, 8'hff, 8'h00, 8'h02, 8'h04, 8'h01, 22'h0, 24'h05, 24'h3ffffb);
    drow(0, 8'hff, 8'h00, 8'h02, 8'h00, 8'h01, 22'h0, 24'h05, 24'h0004fb);
    drow(20, 8'hff, 8'h00, 8'h02, 8'h00, 8'h01, 22'h0, 24'hff, 24'h00fe01);
    drow(0, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 22'd1000, 24'h05, 24'h0003ed);
    drow(0, 8'h01, 8'h02, 8'h03, 8'h00, 8'h01, 22'h0, 24'h05, 24'h00000a);
    drow(7, 8'h01, 8'h00, 8'h02, 8'h08, 8'h01, 22'h0, 24'h0700, 24'h000007);
    drow(7, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 22'h0, 24'h0700, 24'h000000);
  endtask

  task automatic t_swap;
    wr(9'h000, 24'h000001);
    wr(COEF_BANK1_OFF, 24'h000002);
    cfg(8'h02, 8'h01, 8'h01);
    burst(24'h05, 30);
    chk("swap pair", 24'(last[21:0] + prev[21:0]), 24'h00000f);
    wr(9'h000, 24'h000000);
    wr(COEF_BANK1_OFF, 24'h000000);
  endtask

  task automatic t_fifo;
    int base;
    base = n_out;
    cfg(8'h00, 8'h00, 8'h01);
    repeat (FIFO_DEPTH + 1) src.q.push_back(24'h05);
    for (int i = 0; i < 100 && sample_ready !== 1'b0; i++)
      @(negedge clock);
    @(negedge clock);
    chk("ready", {23'h0, sample_ready}, 24'h000000);
    chk("refused", 24'(src.q.size()), 24'h000001);
    chk("held", 24'(n_out - base), 24'h000000);
    wr(ACR_OFF, 24'h000002);
    wait_out(base, FIFO_DEPTH + 1);
  endtask

  task automatic t_stats;
    int base;
    cfg(8'h02, 8'h00, 8'h00);
    srow(8'h00, 24'd100, 24'h0, 22'd50, 24'd50, 24'h1);
    srow(8'h01, 24'd100, 24'h0, 22'd200, 24'd200, 24'h1);
    srow(8'h02, 24'd100, 24'h0, 22'd50, 24'd100, 24'h3);
    srow(8'h02, 24'd100, 24'h0, 22'h3ffffb, 24'd100, 24'h3);
    srow(8'h03, 24'd100, 24'h0, 22'd200, 24'd100, 24'h3);
    srow(8'h03, 24'd100, 24'h0, 22'd100, 24'd100, 24'h0);
    srow(8'h03, 24'd100, 24'h3ffffe, 22'd200, 24'd100, 24'h3fffff);
    // Copies in both directions while samples stream past the monitor
    ld(24'd1000, 24'd5);
    base = n_out;
    repeat (10) src.q.push_back(24'h000000);
    rd_stats(24'd1000, 24'd5);
    wr(CNT_BUF_OFF, 24'd7);
    wr(CNT_COPY_OFF, 24'h000000);
    wait_out(base, 10);
    rd_stats(24'd1000, 24'd7);
  endtask

  task automatic t_ovf;
    wr(9'h000, 24'h000001);
    cfg(8'h02, 8'h00, 8'h00);
    wr(BACKEND_CFG_ONE_OFF, 24'h000001);
    ld(24'h1fffff, 24'h0);
    cascade_in = 22'h1fffff;
    burst(24'h05, 30);
    chk("ovp", {22'h0, last[23:22]}, 24'h000001);
    cfg(8'h02, 8'h02, 8'h00);
    cascade_in = 22'h200000;
    burst(24'hfb, 30);
    chk("ovn", {22'h0, last[23:22]}, 24'h000002);
    rd_stats(24'hdfffff, 24'h0);
    cascade_in = 22'h0;
    ld(24'd100, 24'h0);
    burst(24'h05, 30);
    rd_stats(24'h000064, 24'h0);
    wr(9'h000, 24'h000000);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end

  initial begin
    nrst       = 1'b0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_addr  = '0;
    host_wdata = '0;
    cascade_in = '0;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    t_regs();
    t_path();
    t_swap();
    t_fifo();
    t_stats();
    t_ovf();
    report_and_stop();
  end
endmodule

`default_nettype wire
